// ### logic/maccd_regs.svh
// Offsets, fields, command codes and timing counts of the axis command decoder
// Behaviour
// - Codes 10h-17h clear output bit, pin low
// - Codes 18h-1Fh set output bit, pin high
// - Port 0/1 function 11b, polarity 0: low pulse
// - Port 0/1 function 11b, polarity 1: high pulse
// - One-shot pulse lasts 23 to 25 ms
// - Code 04h performs software reset
// - Codes 20h-23h clear the four counters
// - Code 24h asserts deviation clear output
// - Code 25h releases level-mode deviation clear
// - Code 26h cancels all staged continuous data
// - Code 27h cancels comparator-5 staged data only
// - Shift command advances all staged registers
// - Code 2Ch advances comparator-5 staged register
// - Code 4Fh commits staged data for override
// - Code 28h acts as position-change start input
// - Code 29h latches all four counters together
// - Indirect register access by read/write command codes
// - Read-only registers have no write codes
// - Writes go via second stage; first unreadable
`ifndef MACCD_REGS_SVH
`define MACCD_REGS_SVH
`define MACCD_ADDR_CMD     8'h00
`define MACCD_ADDR_CFG     8'h04
`define MACCD_ADDR_STATUS  8'h08
`define MACCD_CFG_RESET    32'h0000_0000
`define MACCD_CFG_P0FN     1:0
`define MACCD_CFG_P0POL    2
`define MACCD_CFG_P1FN     4:3
`define MACCD_CFG_P1POL    5
`define MACCD_CFG_DEVW     8:6
`define MACCD_FN_ONESHOT   2'h3
`define MACCD_DEVW_LEVEL   3'h7
`define MACCD_C_SOFT_RESET_CMD       8'h04
`define MACCD_C_CLR_LO     8'h10
`define MACCD_C_SET_LO     8'h18
`define MACCD_C_CNT_LO     8'h20
`define MACCD_C_DEV_ON     8'h24
`define MACCD_C_DEV_OFF    8'h25
`define MACCD_C_CAN_ALL    8'h26
`define MACCD_C_CAN_C5     8'h27
`define MACCD_C_PCS        8'h28
`define MACCD_C_LATCH      8'h29
`define MACCD_C_SHF_ALL    8'h2b
`define MACCD_C_SHF_C5     8'h2c
`define MACCD_C_EVT_CLR    8'h2d
`define MACCD_C_ERR_CLR    8'h2e
`define MACCD_C_COMMIT     8'h4f
`define MACCD_CLK_KHZ      50000
`define MACCD_OS_MIN_MS    23
`define MACCD_OS_MAX_MS    25
`define MACCD_OS_CYCLES    (`MACCD_OS_MIN_MS * `MACCD_CLK_KHZ)
`define MACCD_DEV_PULSE    16
`define MACCD_SOFT_RESET_CMD_WAIT    12
`endif

// ### logic/maccd_pkg.sv
// Types shared by the axis command decoder
`default_nettype none
package maccd_pkg;
   typedef struct packed {
      logic cancel_all;
      logic cancel_cmp5;
      logic shift_all;
      logic shift_cmp5;
      logic commit;
   } maccd_stage_t;
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       second;
      logic [5:0] index;
   } maccd_access_t;
endpackage
`default_nettype wire

// ### logic/maccd_top.sv
// Axis control-command decoder with AXI4-Lite register access
`include "maccd_regs.svh"
`default_nettype none
module maccd_top
   import maccd_pkg::*;
#(
   parameter int unsigned ONESHOT_CYCLES = `MACCD_OS_CYCLES
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RESET,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        POSITION_CHANGE_START_INPUT,
   input  wire logic        COUNTER_LATCH_INPUT,
   input  wire logic        EVENT_SET,
   input  wire logic        ERROR_SET,
   output logic [7:0]       GP_OUT,
   output logic             DEVIATION_CLEAR_OUTPUT,
   output logic [3:0]       COUNTER_CLEAR,
   output logic             COUNTER_LATCH,
   output logic             POSITION_CHANGE_START,
   output logic             SOFT_RESET,
   output maccd_stage_t     STAGE_CTRL,
   output maccd_access_t    REG_ACCESS
);
   localparam logic [20:0] OS_LAST  = 21'(ONESHOT_CYCLES - 1);
   localparam logic [4:0]  DEV_LAST = 5'(`MACCD_DEV_PULSE - 1);

   // AXI4-Lite slave: write taken when address and data are both offered
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [1:0]  rresp_q;
   logic [31:0] rdata_q;
   logic [31:0] cfg_q;
   logic [7:0]  last_cmd_q;

   wire wr_hs   = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_q;
   wire rd_hs   = S_AXI_ARVALID & ~rvalid_q;
   wire wa_cmd  = S_AXI_AWADDR == `MACCD_ADDR_CMD;
   wire wa_cfg  = S_AXI_AWADDR == `MACCD_ADDR_CFG;
   wire wa_ok   = wa_cmd | wa_cfg | (S_AXI_AWADDR == `MACCD_ADDR_STATUS);
   wire ra_cmd  = S_AXI_ARADDR == `MACCD_ADDR_CMD;
   wire ra_cfg  = S_AXI_ARADDR == `MACCD_ADDR_CFG;
   wire ra_sts  = S_AXI_ARADDR == `MACCD_ADDR_STATUS;
   wire fire    = wr_hs & wa_cmd & S_AXI_WSTRB[0];
   wire [7:0] cmd = S_AXI_WDATA[7:0];

   assign S_AXI_AWREADY = wr_hs;
   assign S_AXI_WREADY  = wr_hs;
   assign S_AXI_BVALID  = bvalid_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_ARREADY = rd_hs;
   assign S_AXI_RVALID  = rvalid_q;
   assign S_AXI_RRESP   = rresp_q;
   assign S_AXI_RDATA   = rdata_q;

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         bvalid_q <= 1'b0;
         bresp_q  <= 2'h0;
      end else if (wr_hs) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wa_ok ? 2'h0 : 2'h2;
      end else if (S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   // Command decode; each group is a named wire
   wire c_soft_reset_cmd    = fire & (cmd == `MACCD_C_SOFT_RESET_CMD);
   wire c_clr     = fire & (cmd[7:3] == 5'(`MACCD_C_CLR_LO >> 3));
   wire c_set     = fire & (cmd[7:3] == 5'(`MACCD_C_SET_LO >> 3));
   wire c_cnt     = fire & (cmd[7:2] == 6'(`MACCD_C_CNT_LO >> 2));
   wire c_dev_on  = fire & (cmd == `MACCD_C_DEV_ON);
   wire c_dev_off = fire & (cmd == `MACCD_C_DEV_OFF);
   wire c_can_all = fire & (cmd == `MACCD_C_CAN_ALL);
   wire c_can_c5  = fire & (cmd == `MACCD_C_CAN_C5);
   wire c_pcs     = fire & (cmd == `MACCD_C_PCS);
   wire c_latch   = fire & (cmd == `MACCD_C_LATCH);
   wire c_shf_all = fire & (cmd == `MACCD_C_SHF_ALL);
   wire c_shf_c5  = fire & (cmd == `MACCD_C_SHF_C5);
   wire c_evt_clr = fire & (cmd == `MACCD_C_EVT_CLR);
   wire c_err_clr = fire & (cmd == `MACCD_C_ERR_CLR);
   wire c_commit  = fire & (cmd == `MACCD_C_COMMIT);
   wire [2:0] bit_n = cmd[2:0];

   // Indirect access codes; read-only registers have no write code
   wire rd_main = (cmd >= 8'hd0 && cmd <= 8'hf6) || cmd == 8'hfc || cmd == 8'hfd || cmd == 8'hff;
   wire rd_sec  = cmd >= 8'hc0 && cmd <= 8'hcc;
   wire wr_main = (cmd >= 8'h90 && cmd <= 8'hac) || cmd == 8'hb2 || cmd == 8'hb3 || cmd == 8'hbc;
   wire wr_sec  = cmd >= 8'h80 && cmd <= 8'h8c;
   wire acc_hit = fire & (rd_main | rd_sec | wr_main | wr_sec);

   // Soft reset re-initialises all command state but not the bus handshake
   logic soft_reset_cmd_q;
   wire  init = RESET | soft_reset_cmd_q;

   logic [7:0]  gp_q;
   logic [1:0]  os_act_q;
   logic [20:0] os_cnt_q [2];
   logic        dev_q;
   logic [4:0]  dev_cnt_q;
   logic        evt_q;
   logic        err_q;
   logic        armed_q;
   logic [3:0]  cnt_clr_q;
   logic        latch_q;
   logic        pcs_q;
   maccd_stage_t  stage_q;
   maccd_access_t acc_q;

   wire [2:0] devw  = cfg_q[`MACCD_CFG_DEVW];
   wire [1:0] os_fn [2];
   wire [1:0] os_pol;
   assign os_fn[0]  = cfg_q[`MACCD_CFG_P0FN];
   assign os_fn[1]  = cfg_q[`MACCD_CFG_P1FN];
   assign os_pol[0] = cfg_q[`MACCD_CFG_P0POL];
   assign os_pol[1] = cfg_q[`MACCD_CFG_P1POL];

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         soft_reset_cmd_q <= 1'b0;
      end else begin
         soft_reset_cmd_q <= c_soft_reset_cmd;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (init) begin
         gp_q <= 8'h00;
      end else if (c_clr) begin
         gp_q[bit_n] <= 1'b0;
      end else if (c_set) begin
         gp_q[bit_n] <= 1'b1;
      end
   end

   // One-shot timers for ports 0 and 1
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_os
         wire os_mode = os_fn[g] == `MACCD_FN_ONESHOT;
         wire os_trig = os_mode & (bit_n == 3'(g)) &
                        ((c_clr & ~os_pol[g]) | (c_set & os_pol[g]));
         always_ff @(posedge CORE_CLK) begin
            if (init) begin
               os_act_q[g] <= 1'b0;
               os_cnt_q[g] <= 21'h0;
            end else if (os_trig) begin
               os_act_q[g] <= 1'b1;
               os_cnt_q[g] <= 21'h0;
            end else if (os_act_q[g]) begin
               os_cnt_q[g] <= os_cnt_q[g] + 21'h1;
               os_act_q[g] <= os_cnt_q[g] != OS_LAST;
            end
         end
         assign GP_OUT[g] = os_mode ? (os_act_q[g] ? os_pol[g] : ~os_pol[g]) : gp_q[g];
      end
   endgenerate
   assign GP_OUT[7:2] = gp_q[7:2];

   // Deviation clear: level until released in level mode, fixed pulse otherwise
   wire dev_level = devw == `MACCD_DEVW_LEVEL;
   always_ff @(posedge CORE_CLK) begin
      if (init) begin
         dev_q     <= 1'b0;
         dev_cnt_q <= 5'h0;
      end else if (c_dev_on) begin
         dev_q     <= 1'b1;
         dev_cnt_q <= 5'h0;
      end else if (c_dev_off & dev_level) begin
         dev_q     <= 1'b0;
      end else if (dev_q & ~dev_level) begin
         dev_cnt_q <= dev_cnt_q + 5'h1;
         dev_q     <= dev_cnt_q != DEV_LAST;
      end
   end
   assign DEVIATION_CLEAR_OUTPUT = dev_q;

   // Interrupt flags: a hardware set wins over a clear in the same cycle
   always_ff @(posedge CORE_CLK) begin
      if (init) begin
         evt_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         evt_q <= EVENT_SET | (evt_q & ~c_evt_clr);
         err_q <= ERROR_SET | (err_q & ~c_err_clr);
      end
   end

   // Registered one-cycle strobes to the counter and staging logic
   always_ff @(posedge CORE_CLK) begin
      if (init) begin
         cnt_clr_q <= 4'h0;
         latch_q   <= 1'b0;
         pcs_q     <= 1'b0;
         stage_q   <= '0;
         acc_q     <= '0;
         armed_q   <= 1'b0;
      end else begin
         cnt_clr_q <= c_cnt ? 4'h1 << cmd[1:0] : 4'h0;
         latch_q   <= c_latch | COUNTER_LATCH_INPUT;
         pcs_q     <= c_pcs | POSITION_CHANGE_START_INPUT;
         stage_q.cancel_all  <= c_can_all;
         stage_q.cancel_cmp5 <= c_can_c5;
         stage_q.shift_all   <= c_shf_all;
         stage_q.shift_cmp5  <= c_shf_c5;
         stage_q.commit      <= c_commit;
         armed_q   <= c_commit | (armed_q & ~c_can_all);
         acc_q.valid  <= acc_hit;
         acc_q.write  <= wr_main | wr_sec;
         acc_q.second <= rd_sec | wr_sec;
         acc_q.index  <= cmd[5:0];
      end
   end
   assign COUNTER_CLEAR         = cnt_clr_q;
   assign COUNTER_LATCH         = latch_q;
   assign POSITION_CHANGE_START = pcs_q;
   assign STAGE_CTRL            = stage_q;
   assign REG_ACCESS            = acc_q;
   assign SOFT_RESET            = soft_reset_cmd_q;

   // Configuration and last command registers
   always_ff @(posedge CORE_CLK) begin
      if (init) begin
         cfg_q      <= `MACCD_CFG_RESET;
         last_cmd_q <= 8'h00;
      end else begin
         if (wr_hs & wa_cfg) begin
            cfg_q[8:0] <= S_AXI_WDATA[8:0];
         end
         if (fire & (acc_hit | c_soft_reset_cmd | c_clr | c_set | c_cnt | c_dev_on | c_dev_off |
                     c_can_all | c_can_c5 | c_pcs | c_latch | c_shf_all | c_shf_c5 |
                     c_evt_clr | c_err_clr | c_commit)) begin
            last_cmd_q <= cmd;
         end
      end
   end

   wire [31:0] status = {18'h0, armed_q, err_q, evt_q, dev_q, 2'h0, GP_OUT};
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         rvalid_q <= 1'b0;
         rresp_q  <= 2'h0;
         rdata_q  <= 32'h0;
      end else if (rd_hs) begin
         rvalid_q <= 1'b1;
         rresp_q  <= (ra_cmd | ra_cfg | ra_sts) ? 2'h0 : 2'h2;
         rdata_q  <= ra_cmd ? {24'h0, last_cmd_q} :
                     ra_cfg ? {23'h0, cfg_q[8:0]} : ra_sts ? status : 32'h0;
      end else if (S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   // Checks
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);

   a_bit_clear: assert property (c_clr & ~soft_reset_cmd_q & (bit_n > 3'h1) |=> !GP_OUT[$past(bit_n)])
      else $error("bit clear did not drive pin low");
   a_bit_set: assert property (c_set & ~soft_reset_cmd_q & (bit_n > 3'h1) |=> GP_OUT[$past(bit_n)])
      else $error("bit set did not drive pin high");
   a_neg_shot: assert property (fire & ~soft_reset_cmd_q & cmd == `MACCD_C_CLR_LO & os_fn[0] == 2'h3
      & !os_pol[0] & !wa_cfg |=> !GP_OUT[0] [*8])
      else $error("negative one-shot missing");
   a_pos_shot: assert property (fire & ~soft_reset_cmd_q & cmd == `MACCD_C_SET_LO & os_fn[0] == 2'h3
      & os_pol[0] & !wa_cfg |=> GP_OUT[0] [*8])
      else $error("positive one-shot missing");
   a_shot_len: assert property ($fell(os_act_q[0]) & !$past(init) |-> $past(os_cnt_q[0]) == OS_LAST)
      else $error("one-shot ended at wrong length");
   a_soft_reset: assert property (c_soft_reset_cmd |=> SOFT_RESET ##1 (GP_OUT[7:2] == 6'h0 && !evt_q))
      else $error("soft reset did not clear state");
   a_cnt_clear: assert property (c_cnt & ~soft_reset_cmd_q |=> COUNTER_CLEAR == 4'h1 << $past(cmd[1:0]))
      else $error("wrong counter cleared");
   a_dev_on: assert property (c_dev_on & ~soft_reset_cmd_q |=> DEVIATION_CLEAR_OUTPUT)
      else $error("deviation clear not asserted");
   a_dev_off: assert property (c_dev_off & dev_level & ~c_dev_on & ~soft_reset_cmd_q & ~wa_cfg
      |=> !DEVIATION_CLEAR_OUTPUT)
      else $error("deviation clear not released");
   a_evt_clear: assert property (c_evt_clr & !EVENT_SET & ~soft_reset_cmd_q |=> !evt_q)
      else $error("event flag not cleared");
   a_err_keep: assert property (ERROR_SET & ~soft_reset_cmd_q |=> err_q)
      else $error("error set lost");
   a_unused_code: assert property (fire & ~soft_reset_cmd_q & cmd == 8'had |=> !REG_ACCESS.valid
      && $stable(gp_q) && $stable(last_cmd_q))
      else $error("unassigned code had an effect");
endmodule
`default_nettype wire

// ### testbench/maccd_host.sv
// Host model: AXI4-Lite master issuing command bytes and register cycles
`default_nettype none
module maccd_host (
   input  wire logic        clk,
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic        rvalid,
   output logic             rready,
   output logic             hang
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready, hang} = '0;
   // Waits for one handshake edge; a slave that never answers raises hang
   task automatic sync(input int k);
      logic v;
      for (int n = 0; n < 100; n++) begin
         @(negedge clk);
         v = k == 0 ? awready && wready : k == 1 ? bvalid : k == 2 ? arready : rvalid;
         @(posedge clk);
         if (v) return;
      end
      hang <= 1'b1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      sync(0);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      sync(1);
      bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      sync(2);
      arvalid <= 1'b0;
      sync(3);
      rready <= 1'b0;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ### testbench/test_motion_axis_control_command_decoder.sv
// Self-checking bench for the axis command decoder
`default_nettype none
module test_motion_axis_control_command_decoder
   import maccd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OS = 20;
   logic          clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic          rvalid, rready, evt, err, dev, lat, position_change_start_input, soft_reset_cmd, hang, mdev, mlev, mevt, merr, mcom;
   logic          ltin, pcsin;
   logic [1:0]    bresp, rresp;
   logic [3:0]    cclr;
   logic [7:0]    awaddr, araddr, gp, mgp;
   logic [31:0]   wdata, rdata;
   logic [2:0]    pin;
   maccd_stage_t  stg;
   maccd_access_t acc;
   logic [67:0]   wq [$];
   logic [67:0]   rq [$];
   int            run [3];
   int            last [3];
   int            num_errors, n_tests;
   int            seed = 32'h607f;
   maccd_top #(.ONESHOT_CYCLES(OS)) i_dut (
      .CORE_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .POSITION_CHANGE_START_INPUT(pcsin),
      .COUNTER_LATCH_INPUT(ltin), .EVENT_SET(evt), .ERROR_SET(err), .GP_OUT(gp), .DEVIATION_CLEAR_OUTPUT(dev),
      .COUNTER_CLEAR(cclr), .COUNTER_LATCH(lat), .POSITION_CHANGE_START(position_change_start_input), .SOFT_RESET(soft_reset_cmd),
      .STAGE_CTRL(stg), .REG_ACCESS(acc));
   maccd_host i_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .hang(hang));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic fail(input string m);
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask
   task automatic chk_wr(input logic [33:0] g);
      logic [67:0] n;
      n = wq.size() > 0 ? wq.pop_front() : '1;
      n_tests++;
      if ((g & n[67:34]) !== (n[33:0] & n[67:34])) fail("write response or command outputs");
   endtask
   task automatic chk_rd(input logic [33:0] g);
      logic [67:0] n;
      n = rq.size() > 0 ? rq.pop_front() : '1;
      n_tests++;
      if ((g & n[67:34]) !== (n[33:0] & n[67:34])) fail("read response");
   endtask
   task automatic chk_len(input int i, input int e);
      n_tests++;
      if (last[i] !== e) fail("pulse length");
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [33:0] stat();
      return {20'h0, mcom, merr, mevt, mdev, 2'b00, mgp};
   endfunction
   // Updates the pin model, notes the expected response and strobes, then writes
   task automatic send(input logic [7:0] a, input logic [31:0] d);
      logic [7:0]  c;
      logic [29:0] p;
      logic [33:0] m;
      logic        v;
      logic        w;
      c = a == 8'h00 ? d[7:0] : 8'h00;
      w = (c >= 8'h90 && c <= 8'hac) || c == 8'hb2 || c == 8'hb3 || c == 8'hbc || (c >= 8'h80 && c <= 8'h8c);
      v = w || (c >= 8'hc0 && c <= 8'hcc) || (c >= 8'hd0 && c <= 8'hf6) || c inside {8'hfc, 8'hfd, 8'hff};
      if (c[7:4] == 4'h1) mgp[c[2:0]] = c[3];
      if (c == 8'h24) mdev = 1'b1;
      if (c == 8'h25 && mlev) mdev = 1'b0;
      p = {c[7:2] == 6'h08 ? 4'h1 << c[1:0] : 4'h0, c == 8'h29, c == 8'h28, c == 8'h04, c == 8'h26,
           c == 8'h27, c == 8'h2b, c == 8'h2c, c == 8'h4f, v, w, c[7:4] == 4'h8 || c[7:4] == 4'hc,
           c[5:0], mgp, mdev};
      m = a == 8'h04 ? 34'h3_0000_0000 : v ? '1 : ~(34'hff << 9);
      wq.push_back({m, a inside {8'h00, 8'h04, 8'h08} ? 2'b00 : 2'b10, 2'b00, p});
      if (c == 8'h2d) mevt = 1'b0;
      if (c == 8'h2e) merr = 1'b0;
      if (c == 8'h4f) mcom = 1'b1;
      if (c == 8'h26) mcom = 1'b0;
      if (a == 8'h04) mlev = d[8:6] == 3'h7;
      i_host.wr(a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [33:0] m, input logic [33:0] e);
      rq.push_back({m, e});
      i_host.rd(a);
   endtask
   always @(posedge clk) begin
      if (bvalid && bready) chk_wr({bresp, 2'b00, cclr, lat, position_change_start_input, soft_reset_cmd, stg, acc, gp, dev});
      if (rvalid && rready) chk_rd({rresp, rdata});
   end
   // Length of the latest active run of each one-shot or pulse pin
   assign pin = {dev, ~gp[1], gp[0]};
   always @(posedge clk) begin
      for (int i = 0; i < 3; i++) begin
         if (pin[i] === 1'b1) begin
            run[i]++;
         end else if (run[i] != 0) begin
            last[i] = run[i];
            run[i] = 0;
         end
      end
   end
   always @(posedge hang) begin
      num_errors++;
      give_verdict();
   end
   initial begin
      logic [31:0] r;
      {rst, evt, err, mgp, mdev, mlev, mevt, merr, mcom} = 16'h8000;
      {ltin, pcsin} = 2'b00;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      tick(2);
      rdc(8'h04, '1, 34'h0);
      rdc(8'h08, 34'h3_0000_3cff, stat());
      rdc(8'h0c, '1, 34'h2_0000_0000);
      send(8'h0c, 32'h18);
      send(8'h04, 32'h1c0);
      for (int c = 0; c < 256; c++) begin
         r = $random(seed);
         if (c != 4) send(8'h00, {r[23:0], c[7:0]});
      end
      rdc(8'h08, 34'h3_0000_3cff, stat());
      rdc(8'h00, '1, 34'h0_0000_00ff);
      {ltin, pcsin} <= 2'b11;
      tick(1);
      {ltin, pcsin} <= 2'b00;
      @(negedge clk);
      n_tests++;
      if ({lat, position_change_start_input} !== 2'b11) fail("external latch or start not passed on");
      tick(1);
      evt <= 1'b1;
      err <= 1'b1;
      tick(1);
      evt <= 1'b0;
      err <= 1'b0;
      {mevt, merr} = 2'b11;
      rdc(8'h08, 34'h3_0000_3cff, stat());
      send(8'h00, 32'h2d);
      rdc(8'h08, 34'h3_0000_3cff, stat());
      send(8'h00, 32'h2e);
      rdc(8'h08, 34'h3_0000_3cff, stat());
      send(8'h04, 32'h1f);
      mgp[1:0] = 2'b10;
      tick(3);
      send(8'h00, 32'h18);
      tick(30);
      mgp[0] = 1'b0;
      send(8'h00, 32'h11);
      tick(30);
      mgp[1] = 1'b1;
      chk_len(0, OS);
      chk_len(1, OS);
      send(8'h00, 32'h24);
      tick(30);
      mdev = 1'b0;
      chk_len(2, 16);
      send(8'h00, 32'h1a);
      send(8'h00, 32'h04);
      tick(12);
      {mgp, mdev, mevt, merr, mlev, mcom} = '0;
      rdc(8'h08, 34'h3_0000_3cff, stat());
      rdc(8'h04, '1, 34'h0);
      rdc(8'h00, '1, 34'h0);
      send(8'h08, '1);
      rdc(8'h08, 34'h3_0000_3cff, stat());
      tick(2);
      if (wq.size() > 0 || rq.size() > 0) fail("response missing");
      give_verdict();
   end
endmodule
`default_nettype wire
